// file: rtl/hpoe_defs.vh
// constants for the headphone output stage enable register bank
`ifndef HPOE_DEFS_VH
`define HPOE_DEFS_VH

// ---------------------------------------------------------------------
// bus geometry
// ---------------------------------------------------------------------
`define HPOE_ADDR_W 12
`define HPOE_DATA_W 32
`define HPOE_RESP_OKAY 2'h0
`define HPOE_RESP_SLVERR 2'h2

// ---------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define HPOE_CTRL_IDX 10'h05a
`define HPOE_STAT_IDX 10'h05b

// ---------------------------------------------------------------------
// control register fields and reset value
// ---------------------------------------------------------------------
`define HPOE_CTRL_W 8
`define HPOE_CTRL_RST 8'h00
`define HPOE_BIT_L_SHORT_RMV 7
`define HPOE_BIT_L_OUTP 6
`define HPOE_BIT_L_DLY 5
`define HPOE_BIT_L_IN 4
`define HPOE_BIT_R_SHORT_RMV 3
`define HPOE_BIT_R_OUTP 2
`define HPOE_BIT_R_DLY 1
`define HPOE_BIT_R_IN 0

// ---------------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------------
`define HPOE_STAT_BIT_R_SETTLED 0
`define HPOE_STAT_BIT_L_SETTLED 1

// ---------------------------------------------------------------------
// timing: input stage settle time before the intermediate stage
// ---------------------------------------------------------------------
`define HPOE_CLK_PERIOD_PS 5000
`define HPOE_SETTLE_US 20
`define HPOE_SETTLE_CYC \
   ((`HPOE_SETTLE_US * 1000000 + `HPOE_CLK_PERIOD_PS - 1) / `HPOE_CLK_PERIOD_PS)
`define HPOE_CNT_W 13

`endif

// file: rtl/hpoe_ctrl.v
// headphone output stage enable register bank with an axi4-lite slave
// Notes on behaviour
// - bit 7 removes left output short when set
// - bit 6 enables left output stage
// - bit 5 enables left intermediate stage
// - bit 4 enables left input stage
// - bit 3 removes right output short when set
// - bit 2 enables right output stage
// - bit 1 enables right intermediate stage
// - bit 0 enables right input stage
`include "hpoe_defs.vh"

module hpoe_ctrl (
   input wire ref_clk,
   input wire rst,
   // axi4-lite write address
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [`HPOE_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [`HPOE_DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // axi4-lite write response
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   output wire [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [`HPOE_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   // axi4-lite read data
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output wire [`HPOE_DATA_W-1:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   // analogue stage controls
   output wire leftShortRemove,
   output wire leftOutputStageEnable,
   output wire leftIntermediateStageEnable,
   output wire leftInputStageEnable,
   output wire rightShortRemove,
   output wire rightOutputStageEnable,
   output wire rightIntermediateStageEnable,
   output wire rightInputStageEnable
);

   localparam integer SETTLE_CYC = `HPOE_SETTLE_CYC;
   localparam [`HPOE_CNT_W-1:0] SETTLE_LIM = SETTLE_CYC[`HPOE_CNT_W-1:0];

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   reg [`HPOE_CTRL_W-1:0] ctrl_r;
   reg [`HPOE_CTRL_W-1:0] ctrl_nxt;
   reg awReady_r;
   reg wReady_r;
   reg awHeld_r;
   reg wHeld_r;
   reg [9:0] wIdx_r;
   reg [`HPOE_CTRL_W-1:0] wData_r;
   reg wStrb0_r;
   reg bValid_r;
   reg [1:0] bResp_r;
   reg arReady_r;
   reg rValid_r;
   reg [`HPOE_DATA_W-1:0] rData_r;
   reg [1:0] rResp_r;
   wire [1:0] settled;

   wire awTake;
   wire wTake;
   wire doWrite;
   wire bDone;
   wire arTake;
   wire rDone;
   wire [9:0] arIdx;
   wire [1:0] inStage;
   wire awHeldNxt;
   wire wHeldNxt;
   wire bValidNxt;

   assign awTake = s_axi_awvalid & awReady_r;
   assign wTake = s_axi_wvalid & wReady_r;
   assign bDone = bValid_r & s_axi_bready;
   assign doWrite = awHeld_r & wHeld_r & ~bValid_r;
   assign arTake = s_axi_arvalid & arReady_r;
   assign rDone = rValid_r & s_axi_rready;
   assign arIdx = s_axi_araddr[11:2];

   assign awHeldNxt = (awHeld_r & ~doWrite) | awTake;
   assign wHeldNxt = (wHeld_r & ~doWrite) | wTake;
   assign bValidNxt = (bValid_r & ~bDone) | doWrite;

   // ------------------------------------------------------------------
   // write channels: address and data taken in either order
   // ------------------------------------------------------------------
   // ready drops once an item is held, so a second write waits for b
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awReady_r <= 1'b0;
         wReady_r <= 1'b0;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         wIdx_r <= 10'h000;
         wData_r <= `HPOE_CTRL_RST;
         wStrb0_r <= 1'b0;
      end else begin
         awHeld_r <= awHeldNxt;
         wHeld_r <= wHeldNxt;
         awReady_r <= ~awHeldNxt & ~bValidNxt;
         wReady_r <= ~wHeldNxt & ~bValidNxt;
         if (awTake) begin
            wIdx_r <= s_axi_awaddr[11:2];
         end
         if (wTake) begin
            wData_r <= s_axi_wdata[`HPOE_CTRL_W-1:0];
            wStrb0_r <= s_axi_wstrb[0];
         end
      end
   end

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   // no ordering or delay check: software owns the pop-free sequence
   always @* begin
      ctrl_nxt = ctrl_r;
      if (doWrite && wIdx_r == `HPOE_CTRL_IDX && wStrb0_r) begin
         ctrl_nxt = wData_r;
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `HPOE_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ------------------------------------------------------------------
   // write response
   // ------------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bValid_r <= 1'b0;
         bResp_r <= `HPOE_RESP_OKAY;
      end else begin
         bValid_r <= bValidNxt;
         if (doWrite) begin
            if (wIdx_r == `HPOE_CTRL_IDX || wIdx_r == `HPOE_STAT_IDX) begin
               bResp_r <= `HPOE_RESP_OKAY;
            end else begin
               bResp_r <= `HPOE_RESP_SLVERR;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // input stage settle timers
   // ------------------------------------------------------------------
   // a status aid only: lets software poll instead of timing 20us itself
   assign inStage[0] = ctrl_r[`HPOE_BIT_R_IN];
   assign inStage[1] = ctrl_r[`HPOE_BIT_L_IN];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : gSettle
         reg [`HPOE_CNT_W-1:0] cnt_r;
         // own flag per channel: one process drives each bit
         reg settled_r;
         assign settled[ch] = settled_r;
         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               cnt_r <= {`HPOE_CNT_W{1'b0}};
               settled_r <= 1'b0;
            end else if (!inStage[ch]) begin
               cnt_r <= {`HPOE_CNT_W{1'b0}};
               settled_r <= 1'b0;
            end else if (cnt_r != SETTLE_LIM) begin
               cnt_r <= cnt_r + 1'b1;
               settled_r <= 1'b0;
            end else begin
               settled_r <= 1'b1;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arReady_r <= 1'b0;
         rValid_r <= 1'b0;
         rData_r <= 32'h00000000;
         rResp_r <= `HPOE_RESP_OKAY;
      end else begin
         if (arTake) begin
            arReady_r <= 1'b0;
            rValid_r <= 1'b1;
            if (arIdx == `HPOE_CTRL_IDX) begin
               rData_r <= {24'h000000, ctrl_r};
               rResp_r <= `HPOE_RESP_OKAY;
            end else if (arIdx == `HPOE_STAT_IDX) begin
               rData_r <= {30'h00000000, settled};
               rResp_r <= `HPOE_RESP_OKAY;
            end else begin
               rData_r <= 32'h00000000;
               rResp_r <= `HPOE_RESP_SLVERR;
            end
         end else if (rDone) begin
            rValid_r <= 1'b0;
            arReady_r <= 1'b1;
         end else if (!rValid_r) begin
            arReady_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign s_axi_awready = awReady_r;
   assign s_axi_wready = wReady_r;
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_arready = arReady_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;

   // short stays applied while its bit is 0
   assign leftShortRemove = ctrl_r[`HPOE_BIT_L_SHORT_RMV];
   assign leftOutputStageEnable = ctrl_r[`HPOE_BIT_L_OUTP];
   assign leftIntermediateStageEnable = ctrl_r[`HPOE_BIT_L_DLY];
   assign leftInputStageEnable = ctrl_r[`HPOE_BIT_L_IN];
   assign rightShortRemove = ctrl_r[`HPOE_BIT_R_SHORT_RMV];
   assign rightOutputStageEnable = ctrl_r[`HPOE_BIT_R_OUTP];
   assign rightIntermediateStageEnable = ctrl_r[`HPOE_BIT_R_DLY];
   assign rightInputStageEnable = ctrl_r[`HPOE_BIT_R_IN];

endmodule // hpoe_ctrl

// file: verif/hpoe_ctrl_properties.sv
// assertions for the headphone stage enable register bank
`include "hpoe_defs.vh"
module hpoe_ctrl_properties (
   input logic ref_clk,
   input logic rst,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic [`HPOE_ADDR_W-1:0] s_axi_awaddr,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [`HPOE_DATA_W-1:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic leftShortRemove,
   input logic leftOutputStageEnable,
   input logic leftIntermediateStageEnable,
   input logic leftInputStageEnable,
   input logic rightShortRemove,
   input logic rightOutputStageEnable,
   input logic rightIntermediateStageEnable,
   input logic rightInputStageEnable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire [7:0] stages = {leftShortRemove, leftOutputStageEnable,
      leftIntermediateStageEnable, leftInputStageEnable, rightShortRemove,
      rightOutputStageEnable, rightIntermediateStageEnable,
      rightInputStageEnable};
   wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ctrlHit = s_axi_awaddr[11:2] == `HPOE_CTRL_IDX && s_axi_wstrb[0];
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_wr;
      wrTake;
   endsequence
   sequence s_ctrl_wr;
      s_wr ##0 ctrlHit;
   endsequence
   // register loads one edge after the take, sampled one edge later
   property p_left;
      s_ctrl_wr |-> ##2 stages[7:4] == $past(s_axi_wdata[7:4], 2);
   endproperty
   property p_right;
      s_ctrl_wr |-> ##2 stages[3:0] == $past(s_axi_wdata[3:0], 2);
   endproperty
   property p_hold;
      $changed(stages) |-> $past(wrTake && ctrlHit, 2);
   endproperty
   property p_rst;
      $fell(rst) |-> stages == 8'h00;
   endproperty
   property p_bresp;
      s_wr |-> ##2 s_axi_bvalid;
   endproperty
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_rdhold;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_left: assert property (p_left) else $error("left stage bits");
   a_right: assert property (p_right) else $error("right bits");
   a_hold: assert property (p_hold) else $error("stage change");
   a_rst: assert property (p_rst) else $error("reset value");
   a_bresp: assert property (p_bresp) else $error("write answer");
   a_busy: assert property (p_busy) else $error("ready in response");
   a_rd: assert property (p_rd) else $error("read answer");
   a_rdhold: assert property (p_rdhold) else $error("ar ready");
endmodule // hpoe_ctrl_properties

// file: verif/hpoe_ctrl_tb.sv
// self-checking bench for the headphone stage enable register bank
`include "hpoe_defs.vh"
module hpoe_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] CTRL_A = {`HPOE_CTRL_IDX, 2'h0};
   localparam logic [11:0] STAT_A = {`HPOE_STAT_IDX, 2'h0};
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire leftShortRemove, leftOutputStageEnable, leftIntermediateStageEnable;
   wire leftInputStageEnable, rightShortRemove, rightOutputStageEnable;
   wire rightIntermediateStageEnable, rightInputStageEnable;
   wire [7:0] stages = {leftShortRemove, leftOutputStageEnable,
      leftIntermediateStageEnable, leftInputStageEnable, rightShortRemove,
      rightOutputStageEnable, rightIntermediateStageEnable,
      rightInputStageEnable};
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   always #2.5 ref_clk = ~ref_clk;
   hpoe_ctrl i_hpoe_ctrl (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .leftShortRemove, .leftOutputStageEnable, .leftIntermediateStageEnable,
      .leftInputStageEnable, .rightShortRemove, .rightOutputStageEnable,
      .rightIntermediateStageEnable, .rightInputStageEnable);
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
      logic aw, w;
      aw = 1'h1;
      w = 1'h1;
      @(posedge ref_clk);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_bready <= 1'h1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin
            aw = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && s_axi_wready) begin
            w = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge ref_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", s_axi_rdata, exp);
      chk("rresp", s_axi_rresp, er);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // hang guard: the longest test waits one settle time
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         wrap_up;
      end
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      repeat (2) @(posedge ref_clk);
      chk("stages", stages, 32'h0);
      rd(CTRL_A, 32'h0, `HPOE_RESP_OKAY);
      // one bit at a time, out of order: the block must not object
      for (int i = 0; i < 8; i++) begin
         wr(CTRL_A, 32'h1 << i, 4'h1, `HPOE_RESP_OKAY);
         chk("stages", stages, 32'h1 << i);
         rd(CTRL_A, 32'h1 << i, `HPOE_RESP_OKAY);
      end
      wr(CTRL_A, 32'h11, 4'h1, `HPOE_RESP_OKAY);
      rd(STAT_A, 32'h0, `HPOE_RESP_OKAY);
      repeat (`HPOE_SETTLE_CYC) @(posedge ref_clk);
      rd(STAT_A, 32'h3, `HPOE_RESP_OKAY);
      wr(CTRL_A, 32'h33, 4'h1, `HPOE_RESP_OKAY);
      wr(CTRL_A, 32'h77, 4'h1, `HPOE_RESP_OKAY);
      wr(CTRL_A, 32'hff, 4'h1, `HPOE_RESP_OKAY);
      chk("stages", stages, 32'hff);
      wr(CTRL_A, 32'h0, 4'h0, `HPOE_RESP_OKAY);
      chk("stages", stages, 32'hff);
      // status is read-only: a write is answered but changes nothing
      wr(STAT_A, 32'h0, 4'hf, `HPOE_RESP_OKAY);
      chk("stages", stages, 32'hff);
      rd(STAT_A, 32'h3, `HPOE_RESP_OKAY);
      wr(CTRL_A, 32'hffffff5a, 4'hf, `HPOE_RESP_OKAY);
      rd(CTRL_A, 32'h5a, `HPOE_RESP_OKAY);
      wr(12'h0, 32'h0, 4'hf, `HPOE_RESP_SLVERR);
      rd(12'h0, 32'h0, `HPOE_RESP_SLVERR);
      chk("stages", stages, 32'h5a);
      rst <= 1'h1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      repeat (2) @(posedge ref_clk);
      chk("stages", stages, 32'h0);
      rd(CTRL_A, 32'h0, `HPOE_RESP_OKAY);
      wrap_up;
   end
endmodule // hpoe_ctrl_tb

bind hpoe_ctrl hpoe_ctrl_properties i_hpoe_ctrl_properties (.ref_clk, .rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
   .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .leftShortRemove, .leftOutputStageEnable,
   .leftIntermediateStageEnable, .leftInputStageEnable, .rightShortRemove,
   .rightOutputStageEnable, .rightIntermediateStageEnable,
   .rightInputStageEnable);
